// file: pwmsc_channel.sv
// The register addresses and the plain strobed port were left to the implementer.
`default_nettype none
// Contract
// - Sync pulse loads phase into counter
// - Loaded phase gives lead of phase/period*360; the up-down count of 2 x period ticks gives phase/period*180
// - Up-down period lasts twice period value
// - After sync load, programmed direction applies
// - Output A set up-match, cleared down-match
module pwmsc_channel
    import pwmsc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire pwmsc_bus_type bus,
    output logic [DATA_W-1:0] rdata,
    // Sync chain
    input wire logic sync_input_pulse,
    output logic sync_output_pulse,
    // PWM output
    output logic pwm_out_a
);
    pwmsc_ctrl_type ctrl;
    logic [CNT_W-1:0] phase_value;
    logic [CNT_W-1:0] period_value;
    logic [CNT_W-1:0] compare_a;
    logic [CNT_W-1:0] time_base_counter;
    pwmsc_dir_type dir;
    logic sync_seen;
    logic sync_seen_set;
    logic sync_seen_clear;
    logic counting;
    logic at_zero;
    logic at_compare;
    logic zero_event;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_rdata;
    logic next_sync_output_pulse;
    logic next_pwm_out_a;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Register map, one 16-bit word per index:
    //   control - mode, phase load enable, phase direction, sync out select, run.
    //   phase - count loaded by an accepted sync pulse.
    //   period - turn point of the counter.
    //   compare A - match value for output A.
    //   counter - live count, read only.
    //   status - direction up and sync seen; reading status clears sync seen.
    // Unmapped reads return zero and unmapped writes are dropped.

    // Each register has its own process; a write lands on the edge after the
    // strobe, so the time base sees a new value from the following tick on.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (bus.wr && bus.addr == ADDR_CTRL) begin
            ctrl <= pwmsc_ctrl_type'(bus.wdata[$bits(pwmsc_ctrl_type)-1:0]);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_value <= CNT_ZERO;
        end else if (bus.wr && bus.addr == ADDR_PHASE) begin
            phase_value <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            period_value <= CNT_ZERO;
        end else if (bus.wr && bus.addr == ADDR_PERIOD) begin
            period_value <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            compare_a <= CNT_ZERO;
        end else if (bus.wr && bus.addr == ADDR_COMPARE_A) begin
            compare_a <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // Sync arrival record
    // ------------------------------------------------------------
    // A new pulse wins over a read clear in the same tick, so no arrival is lost.
    always_comb begin
        sync_seen_set = sync_input_pulse;
        sync_seen_clear = bus.rd && bus.addr == ADDR_STATUS;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_seen <= 1'b0;
        end else if (sync_seen_set) begin
            sync_seen <= 1'b1;
        end else if (sync_seen_clear) begin
            sync_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // A stopped or halted counter does not move, so a counter parked at zero
    // must not repeat the zero sync on every tick.
    always_comb begin
        counting = ctrl.run && ctrl.count_direction_mode != PWMSC_STOP;
        at_zero = time_base_counter == CNT_ZERO;
        at_compare = time_base_counter == compare_a;
        zero_event = counting && at_zero;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        status_word = DATA_W'({sync_seen, dir == PWMSC_DIR_UP});
    end

    // Read data are zero outside the cycle after a read strobe, so a master
    // may OR several slaves' read buses together.
    always_comb begin
        next_rdata = DATA_ZERO;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL: next_rdata = DATA_W'(ctrl);
                ADDR_PHASE: next_rdata = phase_value;
                ADDR_PERIOD: next_rdata = period_value;
                ADDR_COMPARE_A: next_rdata = compare_a;
                ADDR_COUNTER: next_rdata = time_base_counter;
                ADDR_STATUS: next_rdata = status_word;
                default: next_rdata = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= DATA_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    // The counter and its direction live in one module, so the sync load and
    // the turn points are decided in a single place.
    pwmsc_time_base u_time_base (
        .mclk(mclk),
        .rst(rst),
        .ctrl(ctrl),
        .phase_value(phase_value),
        .period_value(period_value),
        .sync_input_pulse(sync_input_pulse),
        .time_base_counter(time_base_counter),
        .dir(dir)
    );

    // ------------------------------------------------------------
    // Sync output
    // ------------------------------------------------------------
    // Pass-through stays live while the counter is halted, so a chain can be
    // fed through a stopped module.
    always_comb begin
        if (ctrl.sync_out_select) begin
            next_sync_output_pulse = zero_event;
        end else begin
            next_sync_output_pulse = sync_input_pulse;
        end
    end

    // Registered to keep the output a flip-flop; each stage of a chain adds one tick.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_output_pulse <= 1'b0;
        end else begin
            sync_output_pulse <= next_sync_output_pulse;
        end
    end

    // ------------------------------------------------------------
    // Action qualifier, output A
    // ------------------------------------------------------------
    // The output holds its level between matches; a halted counter leaves it alone.
    always_comb begin
        next_pwm_out_a = pwm_out_a;
        if (ctrl.run && at_compare) begin
            case (dir)
                PWMSC_DIR_UP: next_pwm_out_a = 1'b1;
                PWMSC_DIR_DOWN: next_pwm_out_a = 1'b0;
                default: next_pwm_out_a = pwm_out_a;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwm_out_a <= 1'b0;
        end else begin
            pwm_out_a <= next_pwm_out_a;
        end
    end
endmodule
`default_nettype wire

// file: pwmsc_pkg.sv
`default_nettype none
package pwmsc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PHASE = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_A = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h5;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PHEN_BIT = 2;
    localparam int CTRL_PHDIR_BIT = 3;
    localparam int CTRL_SOSEL_BIT = 4;
    localparam int CTRL_RUN_BIT = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    // Counting modes; the 2-bit field value is the enum value.
    typedef enum logic [1:0] {
        PWMSC_UP = 2'h0,
        PWMSC_DOWN = 2'h1,
        PWMSC_UPDOWN = 2'h2,
        PWMSC_STOP = 2'h3
    } pwmsc_mode_type;

    // Direction state, one-hot.
    typedef enum logic [1:0] {
        PWMSC_DIR_UP = 2'b01,
        PWMSC_DIR_DOWN = 2'b10
    } pwmsc_dir_type;

    typedef struct packed {
        logic run;
        logic sync_out_select;
        logic phase_direction;
        logic phase_load_enable;
        pwmsc_mode_type count_direction_mode;
    } pwmsc_ctrl_type;

    localparam pwmsc_ctrl_type CTRL_RESET = '{
        run: 1'b0, sync_out_select: 1'b0, phase_direction: 1'b0,
        phase_load_enable: 1'b0, count_direction_mode: PWMSC_STOP};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pwmsc_bus_type;
endpackage
`default_nettype wire

// file: pwmsc_properties.sv
`default_nettype none
module pwmsc_properties
    import pwmsc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire pwmsc_bus_type bus,
    input wire logic [DATA_W-1:0] rdata,
    // Sync and output
    input wire logic sync_input_pulse,
    input wire logic sync_output_pulse,
    input wire logic pwm_out_a
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow copies, so that rules can be tied to what software wrote.
    logic [DATA_W-1:0] ctl;
    logic [DATA_W-1:0] ph;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl <= DATA_ZERO;
            ph <= DATA_ZERO;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_CTRL) ctl <= bus.wdata;
            if (bus.addr == ADDR_PHASE) ph <= bus.wdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_load; ctl[2] && ctl[5] && sync_input_pulse; endsequence
    sequence s_rd_cnt; bus.rd && bus.addr == ADDR_COUNTER; endsequence
    property p_sync_load; s_load ##1 s_rd_cnt |=> rdata == ph; endproperty
    a_sync_load: assert property (p_sync_load) else $error("phase not loaded");
    property p_pass; !ctl[4] && sync_input_pulse |=> sync_output_pulse; endproperty
    a_pass: assert property (p_pass) else $error("sync not passed");
    property p_pulse; sync_output_pulse |=> !sync_output_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("sync out too long");
    property p_rd_idle; !bus.rd |=> rdata == DATA_ZERO; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_rd_unmapped; bus.rd && bus.addr > ADDR_STATUS |=> rdata == DATA_ZERO; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_halt; !ctl[5] |=> $stable(pwm_out_a); endproperty
    a_halt: assert property (p_halt) else $error("output moved while halted");
endmodule
bind pwmsc_channel pwmsc_properties pwmsc_properties_i (.mclk(mclk), .rst(rst), .bus(bus),
    .rdata(rdata), .sync_input_pulse(sync_input_pulse),
    .sync_output_pulse(sync_output_pulse), .pwm_out_a(pwm_out_a));
`default_nettype wire

// file: pwmsc_sync_master.sv
`default_nettype none
module pwmsc_sync_master
    import pwmsc_pkg::*;
#(
    parameter int PERIOD = 450
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Sync to the slave
    output logic sync_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // The master ignores its own phase and always restarts from zero.
    logic [CNT_W-1:0] cnt;
    logic up;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= CNT_ZERO;
            up <= 1'b1;
            sync_pulse <= 1'b0;
        end else begin
            cnt <= up ? cnt + CNT_ONE : cnt - CNT_ONE;
            up <= up ? (cnt + CNT_ONE != PERIOD[CNT_W-1:0]) : (cnt == CNT_ONE);
            sync_pulse <= (cnt == CNT_ZERO);
        end
    end
endmodule
`default_nettype wire

// file: pwmsc_time_base.sv
`default_nettype none
module pwmsc_time_base
    import pwmsc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Configuration
    input wire pwmsc_ctrl_type ctrl,
    input wire logic [CNT_W-1:0] phase_value,
    input wire logic [CNT_W-1:0] period_value,
    // Sync
    input wire logic sync_input_pulse,
    // State
    output logic [CNT_W-1:0] time_base_counter,
    output pwmsc_dir_type dir
);
    logic sync_load;
    assign sync_load = ctrl.phase_load_enable && sync_input_pulse;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            time_base_counter <= CNT_ZERO;
        end else if (!ctrl.run) begin
            time_base_counter <= time_base_counter;
        end else if (sync_load) begin
            time_base_counter <= phase_value;
        end else begin
            case (ctrl.count_direction_mode)
                PWMSC_UP: begin
                    time_base_counter <= (time_base_counter >= period_value) ? CNT_ZERO
                        : time_base_counter + CNT_ONE;
                end
                PWMSC_DOWN: begin
                    time_base_counter <= (time_base_counter == CNT_ZERO) ? period_value
                        : time_base_counter - CNT_ONE;
                end
                PWMSC_UPDOWN: begin
                    // Turning at the period and at zero gives 2 x period ticks.
                    if (dir == PWMSC_DIR_UP) begin
                        time_base_counter <= (time_base_counter >= period_value)
                            ? time_base_counter - CNT_ONE : time_base_counter + CNT_ONE;
                    end else begin
                        time_base_counter <= (time_base_counter == CNT_ZERO)
                            ? CNT_ONE : time_base_counter - CNT_ONE;
                    end
                end
                default: begin
                    time_base_counter <= time_base_counter;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Direction
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir <= PWMSC_DIR_UP;
        end else if (!ctrl.run) begin
            dir <= dir;
        end else if (sync_load && ctrl.count_direction_mode == PWMSC_UPDOWN) begin
            dir <= ctrl.phase_direction ? PWMSC_DIR_UP : PWMSC_DIR_DOWN;
        end else begin
            case (ctrl.count_direction_mode)
                PWMSC_UP: dir <= PWMSC_DIR_UP;
                PWMSC_DOWN: dir <= PWMSC_DIR_DOWN;
                PWMSC_UPDOWN: begin
                    case (dir)
                        PWMSC_DIR_UP: begin
                            if (time_base_counter >= period_value) begin
                                dir <= PWMSC_DIR_DOWN;
                            end
                        end
                        PWMSC_DIR_DOWN: begin
                            if (time_base_counter == CNT_ZERO) begin
                                dir <= PWMSC_DIR_UP;
                            end
                        end
                        default: dir <= PWMSC_DIR_UP;
                    endcase
                end
                default: dir <= dir;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench import pwmsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 450;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    pwmsc_bus_type bus = '0;
    logic [DATA_W-1:0] rdata;
    logic sync_in;
    logic sync_out;
    logic pwm;
    logic pend = 1'b0;
    int errors = 0;
    int comparisons = 0;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] p;
    logic [DATA_W-1:0] c;
    time t;
    pwmsc_channel pwmsc_channel_i (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
        .sync_input_pulse(sync_in), .sync_output_pulse(sync_out), .pwm_out_a(pwm));
    pwmsc_sync_master #(.PERIOD(P)) pwmsc_sync_master_i (.mclk(mclk), .rst(rst),
        .sync_pulse(sync_in));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic w, input logic r, input logic [DATA_W-1:0] e);
        if (r) exp_q.push_back(e);
        bus <= '{a, d, w, r};
        @(posedge mclk);
    endtask
    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe.
    always @(posedge mclk) begin
        if (pend) chk(rdata, exp_q.pop_front());
        pend = bus.rd;
    end
    initial begin
        #100us;
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h7b9f));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        op(ADDR_CTRL, DATA_ZERO, 1'b0, 1'b1, {10'h000, CTRL_RESET});
        op(ADDR_COUNTER, DATA_ZERO, 1'b0, 1'b1, CNT_ZERO);
        op(4'hf, 16'hffff, 1'b1, 1'b0, DATA_ZERO);
        op(4'hf, DATA_ZERO, 1'b0, 1'b1, DATA_ZERO);
        p = 16'h0010 + 16'($urandom % 48);
        c = 16'h0001 + 16'($urandom % (p - 16'h0001));
        op(ADDR_PERIOD, p, 1'b1, 1'b0, DATA_ZERO);
        op(ADDR_COMPARE_A, c, 1'b1, 1'b0, DATA_ZERO);
        op(ADDR_PERIOD, DATA_ZERO, 1'b0, 1'b1, p);
        op(ADDR_CTRL, 16'h0032, 1'b1, 1'b0, DATA_ZERO);
        op(ADDR_CTRL, DATA_ZERO, 1'b0, 1'b0, DATA_ZERO);
        @(posedge mclk iff sync_out);
        t = $time;
        @(posedge mclk iff sync_out);
        chk(16'(($time - t) / 10), 16'(2 * p));
        @(posedge mclk iff !pwm);
        @(posedge mclk iff pwm);
        t = $time;
        @(posedge mclk iff !pwm);
        chk(16'(($time - t) / 10), 16'(2 * (p - c)));
        op(ADDR_PERIOD, 16'(P), 1'b1, 1'b0, DATA_ZERO);
        // Module two counts down after sync, module three counts up.
        for (int m = 2; m <= 3; m++) begin
            op(ADDR_PHASE, 16'(P / 3 * (m - 1)), 1'b1, 1'b0, DATA_ZERO);
            op(ADDR_CTRL, 16'h0026 | 16'((m - 2) << 3), 1'b1, 1'b0, DATA_ZERO);
            op(ADDR_CTRL, DATA_ZERO, 1'b0, 1'b0, DATA_ZERO);
            @(posedge mclk iff sync_in);
            op(ADDR_COUNTER, DATA_ZERO, 1'b0, 1'b1, 16'(P / 3 * (m - 1)));
            op(ADDR_COUNTER, DATA_ZERO, 1'b0, 1'b1, 16'(P / 3 * (m - 1) + 2 * m - 5));
            op(ADDR_STATUS, DATA_ZERO, 1'b0, 1'b1, 16'h0002 | 16'(m - 2));
            op(ADDR_STATUS, DATA_ZERO, 1'b0, 1'b1, 16'(m - 2));
        end
        op(ADDR_CTRL, DATA_ZERO, 1'b0, 1'b0, DATA_ZERO);
        repeat (2) @(posedge mclk);
        print_verdict();
    end
endmodule
`default_nettype wire
